// ===== jsd_pkg.sv
// Package for the jack sense and descriptor register bank.
// Assumes 16-bit registers at 7-bit word addresses on the codec link port.
package jsd_pkg;
  // Register addresses
  localparam logic [6:0] REG_FUNC_SEL = 7'h66;
  localparam logic [6:0] REG_INFO     = 7'h68;
  localparam logic [6:0] REG_SENSE    = 7'h6A;
  localparam logic [6:0] REG_MISC     = 7'h7A;
  // Field positions
  localparam int SEL_TR_BIT   = 0;
  localparam int SEL_FC_LSB   = 1;
  localparam int INFO_FIP_BIT = 0;
  localparam int INFO_IV_BIT  = 4;
  localparam int INFO_DL_LSB  = 5;
  localparam int INFO_INV_BIT = 10;
  localparam int INFO_G_LSB   = 11;
  localparam int SNS_OR_LSB   = 6;
  localparam int SNS_S_LSB    = 8;
  localparam int SNS_ST_LSB   = 13;
  localparam int STYLE_A_BIT  = 11;
  localparam int STYLE_B_BIT  = 15;
  // Device-type codes
  localparam logic [4:0] OUT_INVALID = 5'h00;
  localparam logic [4:0] OUT_NO_CONN = 5'h01;
  localparam logic [4:0] OUT_VENDOR  = 5'h0A;
  localparam logic [4:0] IN_INVALID  = 5'h10;
  localparam logic [4:0] IN_NO_CONN  = 5'h11;
  localparam logic [4:0] IN_VENDOR   = 5'h1A;
  // Order codes, delay limits, location default
  localparam logic [1:0] ORDER_X1    = 2'h0;
  localparam logic [1:0] ORDER_X1000 = 2'h3;
  localparam logic [4:0] DL_RESERVED = 5'h1F;
  localparam logic [2:0] LOC_REAR    = 3'h0;
  // Function capabilities: supported, input-type, jack served (F = none)
  localparam logic [15:0] FC_SUPPORTED = 16'h1DFF;
  localparam logic [15:0] FC_IS_INPUT  = 16'h05F0;
  localparam logic [15:0][3:0] FC_JACK = 64'hFFF1_F6FF_455F_F320;
  localparam logic [3:0] JACK_NONE = 4'hF;
  // Ladder resistance of each jack in kilohms, jack 7 first
  localparam logic [7:0][5:0] JACK_KOHM =
    {6'h05, 6'h28, 6'h14, 6'h0A, 6'h0A, 6'h14, 6'h28, 6'h05};
  // Sense cycle timing
  localparam int CLK_MHZ          = 40;
  localparam int SENSE_PERIOD_US  = 1000;
  localparam int SENSE_PERIOD_CYC = SENSE_PERIOD_US * CLK_MHZ;
endpackage

// ===== jsd_sync.sv
// Two-flop synchroniser for the sense-line comparator codes.
// Assumes inputs are asynchronous pins; only stage two is read outside.
`timescale 1ns/1ps
module jsd_sync #(
  parameter int W = 8
) (
  input  wire logic         CLK,
  input  wire logic         RESET,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } jsd_sync_st_t;

  jsd_sync_st_t st_r;
  jsd_sync_st_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
    if (RESET) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge CLK) begin
    st_r <= st_nxt;
  end

  assign q = st_r.s2;
endmodule

// ===== jsd_ladder.sv
// Decoder for one resistor-ladder sense line of four jacks.
// Assumes the code is the synchronised conductance word, one bit per rung.
`timescale 1ns/1ps
module jsd_ladder #(
  parameter int W = 4
) (
  input  wire logic [W-1:0] code,
  input  wire logic         nc_style,
  output logic      [W-1:0] present
);
  // Rungs weigh 1:2:4:8, so each bit is one jack's resistor in circuit
  // Closed-style switches open on insertion, hence the inversion
  always_comb begin
    present = code ^ {W{nc_style}};
  end
endmodule

// ===== jsd_regs.sv
// Jack sense and function descriptor register bank, top level.
// Assumes link-side register strobes on CLK and a separate power-on reset.
`timescale 1ns/1ps
module jsd_regs #(
  parameter int SENSE_CYCLES = jsd_pkg::SENSE_PERIOD_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        POWER_ON_RESET,
  input  wire logic        REG_WE,
  input  wire logic        REG_RE,
  input  wire logic [6:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic [3:0]  SENSE_A_CODE,
  input  wire logic [3:0]  SENSE_B_CODE,
  output logic      [15:0] REG_RDATA,
  output logic             REG_RDATA_VALID,
  output logic      [7:0]  JACK_PRESENT,
  output logic             LINE_A_SWITCH_STYLE,
  output logic             LINE_B_SWITCH_STYLE
);
  localparam int CW = $clog2(SENSE_CYCLES + 1);

  typedef struct packed {
    logic [3:0]        fc;
    logic              tr;
    logic              style_a;
    logic              style_b;
    logic [15:0]       rdata;
    logic              rvalid;
    logic [CW-1:0]     cnt;
    logic [7:0]        present;
    logic [15:0][2:0]  loc;
    logic [15:0][4:0]  gain;
    logic [15:0]       phase_invert_flag;
    logic [15:0][4:0]  dl;
    logic [15:0]       iv;
    logic [15:0][4:0]  stype;
    logic [15:0][5:0]  sres;
    logic [15:0][1:0]  ord;
  } jsd_st_t;

  jsd_st_t     st_r;
  jsd_st_t     st_nxt;
  logic [7:0]  code_sync;
  logic [3:0]  pres_a;
  logic [3:0]  pres_b;
  logic [7:0]  pres_now;
  logic        tick;
  logic        wr_sel;
  logic        wr_info;
  logic        wr_sense;
  logic        wr_misc;

  jsd_sync #(
    .W (8)
  ) u_sync (
    .CLK   (CLK),
    .RESET (RESET),
    .d     ({SENSE_A_CODE, SENSE_B_CODE}),
    .q     (code_sync)
  );

  jsd_ladder #(
    .W (4)
  ) u_line_a (
    .code     (code_sync[7:4]),
    .nc_style (st_r.style_a),
    .present  (pres_a)
  );

  jsd_ladder #(
    .W (4)
  ) u_line_b (
    .code     (code_sync[3:0]),
    .nc_style (st_r.style_b),
    .present  (pres_b)
  );

  // Rungs are 4.99k, 10.0k, 20.0k, 40.2k from bit 3 down
  always_comb begin
    pres_now    = '0;
    pres_now[7] = pres_a[3];
    pres_now[4] = pres_a[2];
    pres_now[5] = pres_a[1];
    pres_now[1] = pres_a[0];
    pres_now[0] = pres_b[3];
    pres_now[3] = pres_b[2];
    pres_now[2] = pres_b[1];
    pres_now[6] = pres_b[0];
  end

  assign tick     = (st_r.cnt == CW'(SENSE_CYCLES - 1));
  assign wr_sel   = REG_WE && (REG_ADDR == jsd_pkg::REG_FUNC_SEL);
  assign wr_info  = REG_WE && (REG_ADDR == jsd_pkg::REG_INFO);
  assign wr_sense = REG_WE && (REG_ADDR == jsd_pkg::REG_SENSE);
  assign wr_misc  = REG_WE && (REG_ADDR == jsd_pkg::REG_MISC);

  always_comb begin
    logic [3:0] jk;
    logic       is_in;
    logic       function_info_present;
    jk     = '0;
    is_in  = 1'b0;
    function_info_present    = jsd_pkg::FC_SUPPORTED[st_r.fc];
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;

    // Free-running sense cycle timer
    st_nxt.cnt = tick ? '0 : st_r.cnt + CW'(1);

    // Register writes; info and sense go to the selected function
    if (wr_sel) begin
      st_nxt.fc = REG_WDATA[jsd_pkg::SEL_FC_LSB +: 4];
      st_nxt.tr = REG_WDATA[jsd_pkg::SEL_TR_BIT];
    end
    if (wr_info && function_info_present) begin
      st_nxt.gain[st_r.fc] = REG_WDATA[jsd_pkg::INFO_G_LSB +: 5];
      st_nxt.phase_invert_flag[st_r.fc]  = REG_WDATA[jsd_pkg::INFO_INV_BIT];
      // A reserved delay code is dropped, the old value stays
      if (REG_WDATA[jsd_pkg::INFO_DL_LSB +: 5] != jsd_pkg::DL_RESERVED) begin
        st_nxt.dl[st_r.fc] = REG_WDATA[jsd_pkg::INFO_DL_LSB +: 5];
      end
      if (REG_WDATA[jsd_pkg::INFO_IV_BIT]) begin
        st_nxt.iv[st_r.fc] = 1'b0;
      end
    end
    if (wr_sense && function_info_present) begin
      // Only the location is writable; the rest is sense state
      st_nxt.loc[st_r.fc] = REG_WDATA[jsd_pkg::SNS_ST_LSB +: 3];
    end
    if (wr_misc) begin
      st_nxt.style_a = REG_WDATA[jsd_pkg::STYLE_A_BIT];
      st_nxt.style_b = REG_WDATA[jsd_pkg::STYLE_B_BIT];
    end

    // Sense cycle end: every function refreshes at once; set beats clear
    if (tick) begin
      st_nxt.present = pres_now;
      for (int i = 0; i < 16; i++) begin
        jk    = jsd_pkg::FC_JACK[i];
        is_in = jsd_pkg::FC_IS_INPUT[i];
        if (!jsd_pkg::FC_SUPPORTED[i] || jk == jsd_pkg::JACK_NONE) begin
          st_nxt.stype[i] = is_in ? jsd_pkg::IN_INVALID : jsd_pkg::OUT_INVALID;
          st_nxt.sres[i]  = '0;
          st_nxt.ord[i]   = jsd_pkg::ORDER_X1;
        end else if (pres_now[jk[2:0]]) begin
          // Result in kilohms, so the order is a thousand
          st_nxt.stype[i] = is_in ? jsd_pkg::IN_VENDOR : jsd_pkg::OUT_VENDOR;
          st_nxt.sres[i]  = jsd_pkg::JACK_KOHM[jk[2:0]];
          st_nxt.ord[i]   = jsd_pkg::ORDER_X1000;
        end else begin
          st_nxt.stype[i] = is_in ? jsd_pkg::IN_NO_CONN : jsd_pkg::OUT_NO_CONN;
          st_nxt.sres[i]  = '0;
          st_nxt.ord[i]   = jsd_pkg::ORDER_X1;
        end
        st_nxt.iv[i] = jsd_pkg::FC_SUPPORTED[i];
      end
    end

    // Registered read port, one cycle after the strobe
    if (REG_RE) begin
      st_nxt.rvalid = 1'b1;
      unique case (REG_ADDR)
        jsd_pkg::REG_FUNC_SEL: st_nxt.rdata = {11'h000, st_r.fc, st_r.tr};
        jsd_pkg::REG_INFO: st_nxt.rdata = function_info_present ?
          {st_r.gain[st_r.fc], st_r.phase_invert_flag[st_r.fc], st_r.dl[st_r.fc],
           st_r.iv[st_r.fc], 3'h0, 1'b1} : 16'h0000;
        jsd_pkg::REG_SENSE: st_nxt.rdata =
          {st_r.loc[st_r.fc], st_r.stype[st_r.fc], st_r.ord[st_r.fc], st_r.sres[st_r.fc]};
        jsd_pkg::REG_MISC: st_nxt.rdata = {st_r.style_b, 3'h0, st_r.style_a, 11'h000};
        default: st_nxt.rdata = 16'h0000;
      endcase
    end

    // Link resets spare the firmware-owned location and descriptors
    if (RESET) begin
      st_nxt.fc      = '0;
      st_nxt.tr      = 1'b0;
      st_nxt.rdata   = '0;
      st_nxt.rvalid  = 1'b0;
      st_nxt.cnt     = '0;
      st_nxt.present = '0;
      st_nxt.style_a = 1'b0;
      st_nxt.style_b = 1'b0;
      st_nxt.iv      = '0;
      st_nxt.sres    = '0;
      st_nxt.ord     = '0;
      for (int i = 0; i < 16; i++) begin
        st_nxt.stype[i] = jsd_pkg::FC_IS_INPUT[i] ? jsd_pkg::IN_NO_CONN : jsd_pkg::OUT_NO_CONN;
      end
    end
    if (POWER_ON_RESET) begin
      st_nxt       = '0;
      st_nxt.loc   = {16{jsd_pkg::LOC_REAR}};
      st_nxt.gain  = '0;
      for (int i = 0; i < 16; i++) begin
        st_nxt.stype[i] = jsd_pkg::FC_IS_INPUT[i] ? jsd_pkg::IN_NO_CONN : jsd_pkg::OUT_NO_CONN;
      end
    end
  end

  always_ff @(posedge CLK) begin
    st_r <= st_nxt;
  end

  assign REG_RDATA           = st_r.rdata;
  assign REG_RDATA_VALID     = st_r.rvalid;
  assign JACK_PRESENT        = st_r.present;
  assign LINE_A_SWITCH_STYLE = st_r.style_a;
  assign LINE_B_SWITCH_STYLE = st_r.style_b;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (POWER_ON_RESET);

  logic fip_q;
  assign fip_q = jsd_pkg::FC_SUPPORTED[st_r.fc];

  sequence s_sel_write;
    wr_sel && !RESET;
  endsequence

  sequence s_iv_clear;
    wr_info && REG_WDATA[jsd_pkg::INFO_IV_BIT] && fip_q && !tick && !RESET;
  endsequence

  property p_fsel;
    s_sel_write |=> st_r.fc == $past(REG_WDATA[4:1]);
  endproperty
  a_fsel: assert property (p_fsel) else $error("function select not taken");

  property p_sense_read;
    (REG_RE && REG_ADDR == jsd_pkg::REG_SENSE && !RESET)
      |=> REG_RDATA_VALID && REG_RDATA[15:13] == $past(st_r.loc[st_r.fc]);
  endproperty
  a_sense_read: assert property (p_sense_read) else $error("sense read wrong instance");

  property p_loc_keep;
    RESET |=> st_r.loc == $past(st_r.loc);
  endproperty
  a_loc_keep: assert property (p_loc_keep) else $error("location lost on reset");

  property p_ro_fields;
    (wr_sense && !tick && !RESET) |=> st_r.stype == $past(st_r.stype);
  endproperty
  a_ro_fields: assert property (p_ro_fields) else $error("read-only sense field written");

  property p_vendor_order;
    (st_r.stype[st_r.fc] == jsd_pkg::OUT_VENDOR || st_r.stype[st_r.fc] == jsd_pkg::IN_VENDOR)
      |-> st_r.ord[st_r.fc] == jsd_pkg::ORDER_X1000 && st_r.sres[st_r.fc] != '0;
  endproperty
  a_vendor_order: assert property (p_vendor_order) else $error("vendor code without order");

  property p_gain_keep;
    RESET |=> st_r.gain == $past(st_r.gain) ##1 st_r.phase_invert_flag == $past(st_r.phase_invert_flag, 2);
  endproperty
  a_gain_keep: assert property (p_gain_keep) else $error("gain lost on reset");

  property p_style;
    (wr_misc && !RESET) |=> LINE_A_SWITCH_STYLE == $past(REG_WDATA[11])
      && LINE_B_SWITCH_STYLE == $past(REG_WDATA[15]);
  endproperty
  a_style: assert property (p_style) else $error("switch style not taken");

  property p_iv_clear;
    s_iv_clear |=> !st_r.iv[$past(st_r.fc)];
  endproperty
  a_iv_clear: assert property (p_iv_clear) else $error("valid bit not cleared");

  property p_iv_set;
    (tick && !RESET) |=> st_r.iv == jsd_pkg::FC_SUPPORTED;
  endproperty
  a_iv_set: assert property (p_iv_set) else $error("valid bit not set after sense");

  property p_dl_rsv;
    st_r.dl[st_r.fc] != jsd_pkg::DL_RESERVED;
  endproperty
  a_dl_rsv: assert property (p_dl_rsv) else $error("reserved delay code stored");

  property p_presence;
    (tick && !RESET) |=> JACK_PRESENT == $past(pres_now);
  endproperty
  a_presence: assert property (p_presence) else $error("presence not latched");
endmodule

// ===== jsd_ladder_model.sv
// Resistor-ladder jack switch model for the two sense lines.
// Assumes the bench sets the plugged jacks and the switch style fitted.
`timescale 1ns/1ps
module jsd_ladder_model (
  input  wire logic [7:0] plugged,
  input  wire logic       nc_a,
  input  wire logic       nc_b,
  output logic      [3:0] code_a,
  output logic      [3:0] code_b
);
  // NC wiring puts the rung in circuit while unplugged
  assign code_a = {plugged[7], plugged[4], plugged[5], plugged[1]} ^ {4{nc_a}};
  assign code_b = {plugged[0], plugged[3], plugged[2], plugged[6]} ^ {4{nc_b}};
endmodule

// ===== jack_sense_descriptor_regs_tb.sv
// Self-checking bench for the jack sense and descriptor register bank.
// Assumes the ladder model on the sense pins and a short sense period.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module jack_sense_descriptor_regs_tb;
  typedef struct packed {logic [3:0] fc; logic [2:0] loc; logic [15:0] sense;} jsd_row_t;
  // Short sense period keeps the run brief
  localparam int SC = 16;
  logic        CLK, RESET, POWER_ON_RESET, REG_WE, REG_RE, STYLE_A, STYLE_B, VALID;
  logic [6:0]  REG_ADDR;
  logic [15:0] REG_WDATA, RDATA;
  logic [3:0]  code_a, code_b;
  logic [7:0]  JACK_PRESENT, plugged;
  logic        nc_a, nc_b;
  int          fails, compares;
  jsd_row_t rows [12] = '{
    '{4'h0, 3'h1, 16'h2AC5}, '{4'h1, 3'h2, 16'h4AD4}, '{4'h2, 3'h3, 16'h6100},
    '{4'h3, 3'h7, 16'hE000}, '{4'h4, 3'h0, 16'h1000}, '{4'h5, 3'h1, 16'h3AD4},
    '{4'h6, 3'h2, 16'h5AD4}, '{4'h7, 3'h3, 16'h7100}, '{4'h8, 3'h7, 16'hF000},
    '{4'hA, 3'h0, 16'h1100}, '{4'hB, 3'h1, 16'h2000}, '{4'hC, 3'h2, 16'h4100}};

  jsd_regs #(.SENSE_CYCLES(SC)) u_jsd_regs (.CLK(CLK), .RESET(RESET),
    .POWER_ON_RESET(POWER_ON_RESET), .REG_WE(REG_WE), .REG_RE(REG_RE),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .SENSE_A_CODE(code_a),
    .SENSE_B_CODE(code_b), .REG_RDATA(RDATA), .REG_RDATA_VALID(VALID),
    .JACK_PRESENT(JACK_PRESENT), .LINE_A_SWITCH_STYLE(STYLE_A),
    .LINE_B_SWITCH_STYLE(STYLE_B));
  jsd_ladder_model u_jsd_ladder_model (.plugged(plugged), .nc_a(nc_a), .nc_b(nc_b),
    .code_a(code_a), .code_b(code_b));

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  function automatic logic [15:0] info_of(input logic [3:0] fc);
    info_of = {~fc[0], fc, fc[1], {1'b0, fc} + 5'h01, 5'h00};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge CLK);
    REG_WE    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WE <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] e, input string nm);
    @(posedge CLK);
    REG_RE   <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RE <= 1'b0;
    #1;
    `CHK("read valid", 1'b1, VALID)
    `CHK(nm, e, RDATA)
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Whole sequence needs well under 2000 cycles
  initial begin
    cyc(5000);
    fails++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    RESET = 1'b1;
    POWER_ON_RESET = 1'b1;
    REG_WE = 1'b0;
    REG_RE = 1'b0;
    REG_ADDR = 7'h00;
    REG_WDATA = 16'h0000;
    plugged = 8'hA5;
    nc_a = 1'b0;
    nc_b = 1'b0;
    fails = 0;
    compares = 0;
    cyc(6);
    RESET <= 1'b0;
    POWER_ON_RESET <= 1'b0;
    cyc(40);
    `CHK("presence", 8'hA5, JACK_PRESENT)
    `CHK("style a", 1'b0, STYLE_A)
    // Second pass only selects and reads: each function keeps its own copy
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 12; i++) begin
        wr(7'h66, {11'h000, rows[i].fc, 1'b0});
        rd(7'h66, {11'h000, rows[i].fc, 1'b0}, "function select");
        if (p == 0) begin
          wr(7'h6A, {rows[i].loc, 13'h1FFF});
          wr(7'h68, info_of(rows[i].fc));
        end
        rd(7'h6A, rows[i].sense, "sense word");
        rd(7'h68, info_of(rows[i].fc) | 16'h0011, "info word");
      end
    end
    $display("test rows done");
    // Jacks fitted with NC switches but still read as NO
    nc_a <= 1'b1;
    cyc(40);
    `CHK("presence misread", 8'h17, JACK_PRESENT)
    wr(7'h7A, 16'h0800);
    cyc(40);
    `CHK("presence a", 8'hA5, JACK_PRESENT)
    `CHK("style b", 1'b0, STYLE_B)
    nc_b <= 1'b1;
    wr(7'h7A, 16'h8800);
    cyc(40);
    `CHK("presence b", 8'hA5, JACK_PRESENT)
    rd(7'h7A, 16'h8800, "style word");
    $display("test styles done");
    plugged <= 8'h5A;
    for (int k = 0; k < 60 && JACK_PRESENT !== 8'h5A; k++) begin
      @(posedge CLK);
      #1;
    end
    `CHK("presence new", 8'h5A, JACK_PRESENT)
    rd(7'h6A, 16'h4AE8, "sense plugged");
    // Reserved delay code must leave the old delay in place
    // Start just after a sense tick so no set lands before the read
    @(posedge CLK iff u_jsd_regs.tick);
    wr(7'h68, info_of(4'hC) | 16'h03F0);
    rd(7'h68, info_of(4'hC) | 16'h0001, "valid cleared");
    cyc(20);
    rd(7'h68, info_of(4'hC) | 16'h0011, "valid set again");
    wr(7'h66, 16'h0012);
    rd(7'h68, 16'h0000, "unsupported info");
    wr(7'h70, 16'hFFFF);
    rd(7'h70, 16'h0000, "unmapped");
    $display("test odd cases done");
    wr(7'h66, 16'h0000);
    RESET <= 1'b1;
    cyc(3);
    RESET <= 1'b0;
    rd(7'h6A, 16'h2100, "sense after reset");
    rd(7'h68, info_of(4'h0) | 16'h0001, "info after reset");
    POWER_ON_RESET <= 1'b1;
    cyc(3);
    POWER_ON_RESET <= 1'b0;
    rd(7'h6A, 16'h0100, "sense after power on");
    rd(7'h68, 16'h0001, "info after power on");
    rd(7'h7A, 16'h0000, "style after power on");
    $display("test resets done");
    finish_test();
  end
endmodule
